// ==== bench/fop_properties.sv ====
// checker: timing relations on the offset programming link
`timescale 1ns/100ps
`default_nettype none
module fop_properties (
    input wire logic sys_clk_in,
    input wire logic rd_clk_in,
    input wire logic rst_b_in,
    input wire logic offset_access_sel_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic serial_shift_strobe_n,
    input wire logic [fop_pkg::DATA_WIDTH-1:0] output_bus,
    input wire logic flags_valid,
    input wire logic serial_mode_out
);
    logic ld_q1;
    logic ld_q2;
    wire [3:0] strb = {serial_shift_strobe_n, read_strobe_n, write_strobe_n, offset_access_sel_n};
    wire load_op = serial_mode_out ? (strb == 4'h6) : (strb == 4'hC);
    // two edges of history so a lagging flag update is not taken for a hold
    wire quiet = !load_op && !ld_q1 && !ld_q2;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ld_q1 <= 1'b0;
            ld_q2 <= 1'b0;
        end else begin
            ld_q1 <= load_op;
            ld_q2 <= ld_q1;
        end
    end
    sequence s_settled;
        quiet && flags_valid;
    endsequence
    property p_load_clears;
        @(posedge sys_clk_in) disable iff (!rst_b_in) load_op && !ld_q1 |-> ##[1:3] !flags_valid;
    endproperty
    a_load_clears: assert property (p_load_clears) else $error("flags valid in load");
    property p_rise_quiet;
        @(posedge sys_clk_in) disable iff (!rst_b_in) $rose(flags_valid) |-> !$past(load_op);
    endproperty
    a_rise_quiet: assert property (p_rise_quiet) else $error("flags valid too early");
    property p_sel_low_hold;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
            s_settled ##0 (!offset_access_sel_n && serial_shift_strobe_n) |=> flags_valid;
    endproperty
    a_sel_low_hold: assert property (p_sel_low_hold) else $error("idle shift seen");
    property p_memory_hold;
        @(posedge sys_clk_in) disable iff (!rst_b_in) s_settled ##0 offset_access_sel_n |=> flags_valid;
    endproperty
    a_memory_hold: assert property (p_memory_hold) else $error("memory op hit offsets");
    property p_par_in_serial;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
            s_settled ##0 (serial_mode_out && strb == 4'hC) |=> flags_valid;
    endproperty
    a_par_in_serial: assert property (p_par_in_serial) else $error("wrong method used");
    property p_ser_in_par;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
            s_settled ##0 (!serial_mode_out && strb == 4'h6) |=> flags_valid;
    endproperty
    a_ser_in_par: assert property (p_ser_in_par) else $error("wrong method used");
    property p_mode_fixed;
        @(posedge sys_clk_in) disable iff (!rst_b_in) $past(rst_b_in, 2) |-> $stable(serial_mode_out);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("method changed");
    property p_bus_holds;
        @(posedge rd_clk_in) disable iff (!rst_b_in) !strb[0] && strb[2] |=> $stable(output_bus);
    endproperty
    a_bus_holds: assert property (p_bus_holds) else $error("output bus moved");
endmodule : fop_properties
`default_nettype wire

// ==== bench/tb_flag_offset_programming.sv ====
// testbench: controller and device joined by the link, driven over AHB-Lite
`timescale 1ns/100ps
`default_nettype none
module tb_flag_offset_programming;
    localparam int TOTAL = fop_pkg::DEPTH_SMALL_X9_BITS;
    fop_link_if link ();
    fop_link_if link_w ();
    logic sys_clk = 1'b0, rd_clk = 1'b0, rst_b = 1'b0, dev_rst_b = 1'b1, first_word_fall_through = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hready, hresp, ser_mode, exp_mode, first_edge = 1'b1;
    logic valid_exp = 1'b1;
    logic [1:0] htrans = 2'h0, mem_level = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_word, mem_word;
    logic [fop_pkg::OFFSET_WIDTH-1:0] empty_off, full_off;
    logic [fop_pkg::DATA_WIDTH-1:0] mem_rd;
    logic [39:0] exp_off = 40'h0;
    logic [15:0] lfsr = 16'h13AC;
    int scnt = 0, wp = 0, rp = 0, ser_tot = 0, error_cnt = 0, samples_checked = 0;
    wire dev_rst_all_b = rst_b & dev_rst_b;
    wire [3:0] strb = {link.serial_shift_strobe_n, link.read_strobe_n, link.write_strobe_n,
        link.offset_access_sel_n};
    always #5 sys_clk = ~sys_clk;
    // read clock period chosen so its rising edges never meet the bus clock edges
    always #7.3 rd_clk = ~rd_clk;
    fop_ctrl fop_ctrl_inst (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .link(link.ctrl));
    fop_device #(.LARGE_DEPTH(1'b0), .BOTH_X9(1'b1), .MEM_DEPTH(16)) fop_device_inst (
        .sys_clk_in(sys_clk), .rd_clk_in(rd_clk), .rst_b_in(dev_rst_all_b),
        .partial_rst_b_in(1'b1), .first_word_fall_through_in(first_word_fall_through), .mem_level_in(mem_level),
        .link(link.device), .serial_mode_out(ser_mode), .empty_offset_out(empty_off),
        .full_offset_out(full_off), .mem_rd_data_out(mem_rd));
    fop_properties fop_properties_inst (.sys_clk_in(sys_clk), .rd_clk_in(rd_clk),
        .rst_b_in(dev_rst_all_b), .offset_access_sel_n(link.offset_access_sel_n),
        .write_strobe_n(link.write_strobe_n), .read_strobe_n(link.read_strobe_n),
        .serial_shift_strobe_n(link.serial_shift_strobe_n), .output_bus(link.output_bus),
        .flags_valid(link.flags_valid), .serial_mode_out(ser_mode));
    // wide-bus variant beside the x9 one, fed the same strobes
    assign link_w.offset_access_sel_n = link.offset_access_sel_n;
    assign link_w.write_strobe_n = link.write_strobe_n;
    assign link_w.read_strobe_n = link.read_strobe_n;
    assign link_w.serial_shift_strobe_n = link.serial_shift_strobe_n;
    assign link_w.serial_in = link.serial_in;
    assign link_w.input_bus = link.input_bus;
    fop_device #(.LARGE_DEPTH(1'b0), .BOTH_X9(1'b0), .MEM_DEPTH(16)) fop_device_wide_inst (
        .sys_clk_in(sys_clk), .rd_clk_in(rd_clk), .rst_b_in(dev_rst_all_b),
        .partial_rst_b_in(1'b1), .first_word_fall_through_in(first_word_fall_through), .mem_level_in(mem_level),
        .link(link_w.device), .serial_mode_out(), .empty_offset_out(),
        .full_offset_out(), .mem_rd_data_out());
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic logic [9:0] slot(input int i);
        return exp_off[i*10 +: 10];
    endfunction : slot
    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        rd_word = hrdata;
    endtask : bus
    task automatic cmd(input logic [4:0] v);
        bus(fop_pkg::ADDR_CMD, 1'b1, 32'(v));
        @(negedge sys_clk);
        check("strobes", 40'(v), 40'({link.serial_in, strb}));
    endtask : cmd
    task automatic settle(input string t);
        repeat (20) @(posedge sys_clk);
        mem_level <= lfsr[1:0];
        bus(fop_pkg::ADDR_STATUS, 1'b0, 32'h0);
        check("flags_valid", 40'(valid_exp), 40'(link.flags_valid));
        check("status", 40'(valid_exp), 40'(rd_word[2]));
        check("full_flag_n", 40'(!(valid_exp && mem_level[1])), 40'(rd_word[1]));
        check("empty_flag_n", 40'(!(valid_exp && !mem_level[0])), 40'(rd_word[0]));
        check("offsets", exp_off, {full_off, empty_off});
        check("method", 40'(exp_mode), 40'(ser_mode));
        $display("test %s done", t);
    endtask : settle
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // reference of the device, fed from the link
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!dev_rst_all_b) begin
            exp_off = 40'h0;
            scnt = 0;
            wp = 0;
            first_edge = 1'b1;
            valid_exp = 1'b1;
        end else if (first_edge) begin
            first_edge = 1'b0;
            exp_mode = link.offset_access_sel_n;
        end else if (exp_mode && strb == 4'h6) begin
            exp_off[(scnt < TOTAL / 2) ? scnt : scnt - TOTAL / 2 + fop_pkg::OFFSET_WIDTH] =
                link.serial_in;
            ser_tot++;
            valid_exp = (scnt == TOTAL - 1);
            scnt = valid_exp ? 0 : scnt + 1;
        end else if (!exp_mode && strb == 4'hC) begin
            exp_off[wp*10 +: 10] = link.input_bus[9:0];
            valid_exp = (wp == 3);
            wp = (wp + 1) % 4;
        end
    end
    always @(posedge rd_clk) begin
        if (!dev_rst_all_b) begin
            rp = 0;
        end else if (strb == 4'hA) begin
            rp = (rp + 1) % 4;
            @(negedge rd_clk);
            check("readback", 40'(slot((rp + 3) % 4)), 40'(link.output_bus[9:0]));
        end
    end
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        settle("reset");
        // each shift command stands for three write edges
        for (int n = 0; n < TOTAL / 3; n++) begin
            lfsr = lfsr_next(lfsr);
            if (n == 4) begin
                cmd(5'h0E);
                check("partial", 40'h0, 40'(link.flags_valid));
                cmd(5'h07);
                bus(fop_pkg::ADDR_WDATA, 1'b1, 32'(lfsr));
                cmd(5'h0D);
            end
            cmd({lfsr[0], 4'h6});
        end
        cmd(5'h0E);
        settle("serial load");
        check("serial_bits", 40'(TOTAL), 40'(ser_tot));
        check("wide_valid", 40'(ser_tot % (TOTAL - fop_pkg::WIDE_BUS_BIT_SAVING) == 0),
            40'(link_w.flags_valid));
        cmd(5'h0C);
        cmd(5'h0A);
        cmd(5'h0E);
        settle("serial readback");
        first_word_fall_through <= 1'b1;
        dev_rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        dev_rst_b <= 1'b1;
        settle("parallel reset");
        for (int j = 0; j < 4; j++) begin
            lfsr = lfsr_next(lfsr);
            bus(fop_pkg::ADDR_WDATA, 1'b1, 32'(lfsr));
            cmd(5'h0C);
            cmd(5'h0E);
            if (j == 2) settle("parallel partial");
        end
        cmd(5'h0A);
        cmd(5'h16);
        cmd(5'h0E);
        settle("parallel load");
        mem_word = 32'(lfsr_next(lfsr));
        bus(fop_pkg::ADDR_WDATA, 1'b1, mem_word);
        cmd(5'h0D);
        cmd(5'h0B);
        cmd(5'h0F);
        settle("memory");
        check("mem_data", 40'(mem_word[17:0]), 40'(mem_rd));
        bus(32'h0000_0010, 1'b0, 32'h0);
        check("unmapped", 40'h0, 40'(rd_word));
        complete_run();
    end
endmodule : tb_flag_offset_programming
`default_nettype wire

// ==== verilog/fop_ctrl.sv ====
// controller end: AHB-Lite command registers driving the strobes
`timescale 1ns/100ps
`default_nettype none
module fop_ctrl (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    fop_link_if.ctrl link
);
    // -------------------------------------------------------------
    // bus slave, zero wait states
    // -------------------------------------------------------------
    logic [4:0] cmd_q;
    logic wr_ph_q;
    logic [31:0] addr_q;
    wire logic take = hsel_in && htrans_in[1] && hready_in;
    // controller pauses serial load by raising a strobe [R13]; full set each time [R10]
    wire logic is_cmd = addr_q == fop_pkg::ADDR_CMD;
    wire logic is_wd = addr_q == fop_pkg::ADDR_WDATA;
    wire logic [31:0] rd_mux = (haddr_in == fop_pkg::ADDR_CMD) ? {27'h0, cmd_q}
        : (haddr_in == fop_pkg::ADDR_WDATA) ? {14'h0, link.input_bus}
        : (haddr_in == fop_pkg::ADDR_STATUS) ? {29'h0, link.flags_valid,
            link.almost_full_flag_n, link.almost_empty_flag_n}
        : (haddr_in == fop_pkg::ADDR_RDATA) ? {14'h0, link.output_bus} : 32'h0;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cmd_q <= fop_pkg::CMD_RESET;
            wr_ph_q <= 1'b0;
            addr_q <= 32'h0;
            hrdata_out <= 32'h0;
            link.input_bus <= '0;
        end else begin
            wr_ph_q <= take && hwrite_in;
            if (take) begin
                addr_q <= haddr_in;
            end
            if (take && !hwrite_in) begin
                hrdata_out <= rd_mux;
            end
            if (wr_ph_q && is_cmd) begin
                cmd_q <= hwdata_in[4:0];
            end
            if (wr_ph_q && is_wd) begin
                link.input_bus <= hwdata_in[fop_pkg::DATA_WIDTH-1:0];
            end
        end
    end
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign link.offset_access_sel_n = cmd_q[fop_pkg::CMD_SEL_BIT];
    assign link.write_strobe_n = cmd_q[fop_pkg::CMD_WEN_BIT];
    assign link.read_strobe_n = cmd_q[fop_pkg::CMD_REN_BIT];
    assign link.serial_shift_strobe_n = cmd_q[fop_pkg::CMD_SEN_BIT];
    assign link.serial_in = cmd_q[fop_pkg::CMD_SI_BIT];
    wire logic unused_ok = ^hsize_in;
endmodule : fop_ctrl
`default_nettype wire

// ==== verilog/fop_device.sv ====
// device end: offset registers, pointers, serial counter, flag validity
//
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: parallel write fills slots empty-lsb through full-msb
// R2: parallel read cycles slots onto output bus
// R3: serial shift one bit per edge, lsb first
// R4: x9 serial load needs 36 or 38
// R5: wide modes need two fewer bits
// R6: select high routes strobes to memory
// R7: load method latched only at master reset
// R8: parallel readback works in either method
// R9: sequence identical in both timing modes
// R10: serial reprogramming always supplies full set
// R11: serial strobe high shifts nothing
// R12: memory writes allowed; serial resumes in place
// R13: controller pauses via strobe or select
// R14: flags invalid from load start to end
// R15: full flag valid two write edges later
// R16: empty flag valid two read edges later; the code takes four, through the three-stage toggle sync
// R17: no serial readout, parallel only
// R18: select high at reset means serial
// R19: master reset homes both slot pointers
// R20: bit counter holds across pauses
module fop_device #(
    parameter bit LARGE_DEPTH = 1'b0,
    parameter bit BOTH_X9 = 1'b1,
    parameter int MEM_DEPTH = 16
) (
    input wire logic sys_clk_in,
    input wire logic rd_clk_in,
    input wire logic rst_b_in,
    input wire logic partial_rst_b_in,
    input wire logic first_word_fall_through_in,
    input wire logic [1:0] mem_level_in,
    fop_link_if.device link,
    output logic serial_mode_out,
    output logic [fop_pkg::OFFSET_WIDTH-1:0] empty_offset_out,
    output logic [fop_pkg::OFFSET_WIDTH-1:0] full_offset_out,
    output logic [fop_pkg::DATA_WIDTH-1:0] mem_rd_data_out
);
    // -------------------------------------------------------------
    // strobe decode
    // -------------------------------------------------------------
    localparam int TOTAL_BITS = (LARGE_DEPTH ? fop_pkg::DEPTH_LARGE_X9_BITS
        : fop_pkg::DEPTH_SMALL_X9_BITS) - (BOTH_X9 ? 0 : fop_pkg::WIDE_BUS_BIT_SAVING); // [R4] [R5]
    localparam logic [5:0] LAST_BIT = 6'(TOTAL_BITS - 1);
    localparam int AW = $clog2(MEM_DEPTH);
    // strobes come from the controller's sys_clk_in registers and are sampled directly on both device clocks; no synchroniser
    // first_word_fall_through_in is unused by decode on purpose [R9]
    wire logic sel_n = link.offset_access_sel_n;
    wire logic op_par_wr = !sel_n && !link.write_strobe_n && link.read_strobe_n
        && link.serial_shift_strobe_n && !serial_mode_out; // [R1]
    wire logic op_par_rd = !sel_n && link.write_strobe_n && !link.read_strobe_n
        && link.serial_shift_strobe_n; // [R2] [R8] [R17]
    wire logic op_ser = !sel_n && !link.serial_shift_strobe_n && link.write_strobe_n
        && link.read_strobe_n && serial_mode_out; // [R3] [R11] [R12]
    wire logic op_mem_wr = sel_n && !link.write_strobe_n; // [R6]
    wire logic op_mem_rd = sel_n && !link.read_strobe_n; // [R6]

    logic [5:0] bit_cnt_q;
    logic [1:0] wr_ptr_q;
    logic [1:0] rd_ptr_q;
    logic [fop_pkg::SLOT_WIDTH-1:0] slot_q [fop_pkg::SLOT_COUNT];
    logic [fop_pkg::DATA_WIDTH-1:0] mem_q [MEM_DEPTH];
    logic [AW-1:0] mem_wp_q;
    logic [AW-1:0] mem_rp_q;
    logic loading_q;
    logic af_ok_q;
    logic done_tgl_q;
    logic [2:0] tgl_sync_q;
    logic ae_valid_q;
    logic strap_q;
    wire logic ser_last = op_ser && (bit_cnt_q == LAST_BIT);
    wire logic par_last = op_par_wr && (wr_ptr_q == fop_pkg::SLOT_FULL_MSB);
    // serial bit k goes to bit k of the empty offset, the second half to the full offset
    localparam int HALF_BITS = TOTAL_BITS / 2;
    wire logic ser_hi = bit_cnt_q >= 6'(HALF_BITS);
    wire logic [5:0] ser_pos = ser_hi ? bit_cnt_q - 6'(HALF_BITS) : bit_cnt_q;
    wire logic ser_up = ser_pos >= 6'(fop_pkg::SLOT_WIDTH);
    wire logic [1:0] ser_slot = {ser_hi, ser_up};
    wire logic [5:0] ser_idx = ser_up ? ser_pos - 6'(fop_pkg::SLOT_WIDTH) : ser_pos;

    // -------------------------------------------------------------
    // method strap, caught at first edge after release
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            strap_q <= 1'b0;
            serial_mode_out <= 1'b0;
        end else if (!strap_q) begin
            strap_q <= 1'b1;
            serial_mode_out <= sel_n; // [R7] [R18]
        end
    end

    // -------------------------------------------------------------
    // write-clock side: slots, pointers, counter, memory
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_q <= fop_pkg::SLOT_EMPTY_LSB; // [R19]
            bit_cnt_q <= 6'h00; // [R20]
            loading_q <= 1'b0;
            done_tgl_q <= 1'b0;
            mem_wp_q <= '0;
            for (int i = 0; i < fop_pkg::SLOT_COUNT; i++) begin
                slot_q[i] <= '0;
            end
        end else begin
            if (op_par_wr) begin
                slot_q[wr_ptr_q] <= link.input_bus[fop_pkg::SLOT_WIDTH-1:0]; // [R1]
                wr_ptr_q <= wr_ptr_q + 2'h1;
            end
            if (op_ser) begin
                // placed by count, so a short load still starts at empty-lsb bit 0
                slot_q[ser_slot][ser_idx[3:0]] <= link.serial_in; // [R3]
                bit_cnt_q <= ser_last ? 6'h00 : bit_cnt_q + 6'h01; // [R20]
            end
            if (op_ser || op_par_wr) begin
                loading_q <= !(ser_last || par_last); // [R14]
            end
            if (ser_last || par_last) begin
                done_tgl_q <= !done_tgl_q;
            end
            if (op_mem_wr) begin
                mem_q[mem_wp_q] <= link.input_bus; // [R6] [R12]
                mem_wp_q <= mem_wp_q + 1'b1;
            end
        end
    end

    // full-side validity two write edges after completion
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            af_ok_q <= 1'b1;
        end else begin
            af_ok_q <= !(op_ser || op_par_wr) && !loading_q; // [R15]
        end
    end

    // -------------------------------------------------------------
    // read-clock side: readback pointer, memory read, empty validity
    // -------------------------------------------------------------
    wire logic ae_event = tgl_sync_q[2] ^ tgl_sync_q[1];
    always_ff @(posedge rd_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_ptr_q <= fop_pkg::SLOT_EMPTY_LSB; // [R19]
            link.output_bus <= '0;
            mem_rd_data_out <= '0;
            mem_rp_q <= '0;
            tgl_sync_q <= 3'h0;
            ae_valid_q <= 1'b1;
        end else begin
            tgl_sync_q <= {tgl_sync_q[1:0], done_tgl_q};
            if (op_par_rd) begin
                link.output_bus <= {{(fop_pkg::DATA_WIDTH - fop_pkg::SLOT_WIDTH){1'b0}},
                    slot_q[rd_ptr_q]}; // [R2]
                rd_ptr_q <= rd_ptr_q + 2'h1;
            end
            if (op_mem_rd) begin
                mem_rd_data_out <= mem_q[mem_rp_q]; // [R6]
                mem_rp_q <= mem_rp_q + 1'b1;
            end
            // a completion seen while a new load runs is dropped; that load toggles again
            if (loading_q) begin
                ae_valid_q <= 1'b0; // [R14]
            end else if (ae_event) begin
                ae_valid_q <= 1'b1; // [R16]
            end
        end
    end

    // -------------------------------------------------------------
    // flag outputs; threshold compare lives elsewhere
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            link.almost_full_flag_n <= 1'b1;
            link.flags_valid <= 1'b1;
            empty_offset_out <= '0;
            full_offset_out <= '0;
        end else begin
            link.almost_full_flag_n <= !(af_ok_q && mem_level_in[1]); // [R15]
            link.flags_valid <= af_ok_q && ae_valid_q;
            empty_offset_out <= {slot_q[1], slot_q[0]};
            full_offset_out <= {slot_q[3], slot_q[2]};
        end
    end
    always_ff @(posedge rd_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            link.almost_empty_flag_n <= 1'b0;
        end else begin
            link.almost_empty_flag_n <= !(ae_valid_q && !mem_level_in[0]); // [R16]
        end
    end
    wire logic unused_ok = first_word_fall_through_in & partial_rst_b_in; // [R9]
endmodule : fop_device
`default_nettype wire

// ==== verilog/fop_link_if.sv ====
// interface: strobes, buses and flags between controller and device
`timescale 1ns/100ps
`default_nettype none
interface fop_link_if;
    logic offset_access_sel_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic serial_shift_strobe_n;
    logic serial_in;
    logic [fop_pkg::DATA_WIDTH-1:0] input_bus;
    logic [fop_pkg::DATA_WIDTH-1:0] output_bus;
    logic almost_empty_flag_n;
    logic almost_full_flag_n;
    logic flags_valid;
    modport device (
        input offset_access_sel_n, write_strobe_n, read_strobe_n,
        input serial_shift_strobe_n, serial_in, input_bus,
        output output_bus, almost_empty_flag_n, almost_full_flag_n, flags_valid
    );
    modport ctrl (
        output offset_access_sel_n, write_strobe_n, read_strobe_n,
        output serial_shift_strobe_n, serial_in, input_bus,
        input output_bus, almost_empty_flag_n, almost_full_flag_n, flags_valid
    );
endinterface : fop_link_if
`default_nettype wire

// ==== verilog/fop_pkg.sv ====
// package: constants shared by the offset programming ends
package fop_pkg;
    localparam int DEPTH_SMALL_X9_BITS = 36;
    localparam int DEPTH_LARGE_X9_BITS = 38;
    localparam int WIDE_BUS_BIT_SAVING = 2;
    localparam int SLOT_COUNT = 4;
    localparam logic [1:0] SLOT_EMPTY_LSB = 2'h0;
    localparam logic [1:0] SLOT_EMPTY_MSB = 2'h1;
    localparam logic [1:0] SLOT_FULL_LSB = 2'h2;
    localparam logic [1:0] SLOT_FULL_MSB = 2'h3;
    localparam int FLAG_VALID_EDGES = 2;
    localparam int DATA_WIDTH = 18;
    localparam int SLOT_WIDTH = 10;
    localparam int OFFSET_WIDTH = 2 * SLOT_WIDTH;
    localparam int CNT_WIDTH = 6;
    // controller command register byte offsets and fields
    localparam logic [31:0] ADDR_CMD = 32'h0000_0000;
    localparam logic [31:0] ADDR_WDATA = 32'h0000_0004;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
    localparam logic [31:0] ADDR_RDATA = 32'h0000_000C;
    localparam int CMD_SEL_BIT = 0;
    localparam int CMD_WEN_BIT = 1;
    localparam int CMD_REN_BIT = 2;
    localparam int CMD_SEN_BIT = 3;
    localparam int CMD_SI_BIT = 4;
    localparam logic [4:0] CMD_RESET = 5'h0F;
    typedef enum logic [2:0] {
        FOP_IDLE = 3'h0,
        FOP_PAR_WRITE = 3'h1,
        FOP_PAR_READ = 3'h2,
        FOP_SER_SHIFT = 3'h3,
        FOP_MEM_WRITE = 3'h4,
        FOP_MEM_READ = 3'h5
    } fop_op_t;
endpackage : fop_pkg
